/* cif_core_flags.v */
// Core interrupt flags, register banks and address map behind APB
// Notes on behaviour
// (R01) Enable flag zero blocks maskable interrupts
// (R02) Acknowledge of any interrupt clears enable; software numbers above 1Fh leave it set
// (R03) Stack select picks interrupt or user pointer
// (R04) Hardware ack or low software number clears select
// (R05) Priority level is three bits, zero to seven
// (R06) Accept only strictly higher request priority
// (R07) Reserved flag bit written zero, reads undefined
// (R08) Decode full 1 Mbyte space
// (R09) Program ROM ends at 0FFFFh, grows down
// (R10) Vector table at 0FFDCh to 0FFFFh
// (R11) RAM starts 00400h, grows upward
// (R12) RAM holds data, returns and interrupt stack
// (R13) Peripheral registers in 00000h to 002FFh
// (R14) Software avoids unassigned special addresses
// (R15) Data flash at 02400h to 02BFFh
// (R16) Thirteen core registers, seven banked twice
// (R17) Enable and priority checked together
// (R18) Unassigned special reads harmless, writes ignored
`timescale 1ns/10ps
`default_nettype none
`include "cif_defines.vh"
module cif_core_flags (
  input wire mclk_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg irq_take_o,
  output reg ien_o,
  output reg usel_o,
  output reg [2:0] ppl_o,
  output reg [5:0] region_o
);
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg ien;
  reg usel;
  reg [2:0] ppl;
  reg req;
  reg [2:0] req_lvl;
  reg [19:0] dec_addr;
  reg bank;
  reg [15:0] interrupt_stack_pointer;
  reg [15:0] user_stack_pointer;
  reg [15:0] core [0:`CIF_NUM_CORE+`CIF_NUM_BANKED-1];
  wire accept;
  wire [5:0] region;
  wire setup;
  wire wr;
  wire [4:0] cidx;
  wire [4:0] phys;
  wire core_hit;
  wire [15:0] sp_sel;
  wire swi_hit;
  wire hw_ack;
  reg [31:0] rdata;
  reg err;

  cif_irq_arb cif_irq_arb_i (
    .ien_i(ien),
    .ppl_i(ppl),
    .req_i(req),
    .req_lvl_i(req_lvl),
    .accept_o(accept)
  );

  cif_addr_dec cif_addr_dec_i (
    .addr_i(dec_addr),
    .dfl_en_i(`CIF_HAS_DFL),
    .region_o(region)
  );

  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && (state == ST_DONE);
  // Core register n sits at CORE + 4*n, n = 0..12
  assign cidx = paddr_i[6:2] - 5'h08;
  assign core_hit = (paddr_i[11:7] == 5'h00) && (paddr_i[6:5] != 2'b00) &&
                    (cidx < 5'h0D);
  // Bank one copies of entries 0..6 live in slots 13..19 of their own, so
  // switching banks never disturbs the unbanked entries 7..12
  assign phys = (bank && cidx < 5'h07) ? cidx + 5'h0D : cidx; // (R16)
  assign sp_sel = usel ? user_stack_pointer :
                  interrupt_stack_pointer; // (R03)
  assign hw_ack = accept;
  assign swi_hit = wr && (paddr_i == `CIF_OFF_SWI) &&
                   (pwdata_i[5:0] <= `CIF_SWI_MAX);

  // No wait state: setup latches read data and error, access completes next edge
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (setup) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    rdata = 32'h00000000;
    err = 1'b0;
    if (paddr_i == `CIF_OFF_FLAGS) begin
      rdata[`CIF_BIT_IEN] = ien;
      rdata[`CIF_BIT_USEL] = usel;
      rdata[`CIF_BIT_RSV] = 1'b0; // (R07)
      rdata[`CIF_POS_PPL +: `CIF_W_PPL] = ppl;
    end else if (paddr_i == `CIF_OFF_REQ) begin
      rdata = {28'h0000000, req_lvl, req};
    end else if (paddr_i == `CIF_OFF_ACK) begin
      rdata = {16'h0000, sp_sel};
    end else if (paddr_i == `CIF_OFF_DEC_ADDR) begin
      rdata = {12'h000, dec_addr};
    end else if (paddr_i == `CIF_OFF_DEC_RES) begin
      rdata = {26'h0000000, region};
    end else if (paddr_i == `CIF_OFF_BANK) begin
      rdata = {31'h00000000, bank};
    end else if (core_hit) begin
      rdata = {16'h0000, core[phys]};
    end else if (paddr_i != `CIF_OFF_SWI) begin
      rdata = `CIF_RSV_READ; // (R18)
      err = 1'b1;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      state <= next_state;
      pready_o <= setup;
      pslverr_o <= setup ? err : 1'b0;
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h00000000 : rdata;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ien <= `CIF_RST_IEN;
      usel <= `CIF_RST_USEL;
      ppl <= `CIF_RST_PPL;
      req <= 1'b0;
      req_lvl <= 3'h0;
      dec_addr <= 20'h00000;
      bank <= 1'b0;
      interrupt_stack_pointer <= 16'h0000;
      user_stack_pointer <= 16'h0000;
    end else begin
      if (wr && paddr_i == `CIF_OFF_FLAGS && pstrb_i[0]) begin
        ien <= pwdata_i[`CIF_BIT_IEN];
        usel <= pwdata_i[`CIF_BIT_USEL];
        ppl <= pwdata_i[`CIF_POS_PPL +: `CIF_W_PPL]; // (R05)
      end
      if (wr && paddr_i == `CIF_OFF_REQ && pstrb_i[0]) begin
        req <= pwdata_i[0];
        req_lvl <= pwdata_i[3:1];
      end
      if (wr && paddr_i == `CIF_OFF_DEC_ADDR) begin
        dec_addr <= pwdata_i[19:0]; // (R08)
      end
      if (wr && paddr_i == `CIF_OFF_BANK && pstrb_i[0]) begin
        bank <= pwdata_i[0];
      end
      // Stack pointer slots written through the acknowledge register
      if (wr && paddr_i == `CIF_OFF_ACK) begin
        if (usel) begin
          user_stack_pointer <= pwdata_i[15:0];
        end else begin
          interrupt_stack_pointer <= pwdata_i[15:0];
        end
      end
      // Hardware acceptance overrides a same-cycle flag write
      if (hw_ack) begin
        ien <= 1'b0; // (R02)
        usel <= 1'b0; // (R04)
        ppl <= req_lvl;
        req <= 1'b0;
      end
      if (swi_hit) begin
        usel <= 1'b0; // (R04)
        ien <= 1'b0; // (R02)
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CIF_NUM_CORE + `CIF_NUM_BANKED; g = g + 1)
    begin : g_core
      always @(posedge mclk_i) begin
        if (!rst_b_i) begin
          core[g] <= 16'h0000;
        end else if (wr && core_hit && phys == g) begin
          core[g] <= pwdata_i[15:0]; // (R16)
        end
      end
    end
  endgenerate

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      irq_take_o <= 1'b0;
      ien_o <= `CIF_RST_IEN;
      usel_o <= `CIF_RST_USEL;
      ppl_o <= `CIF_RST_PPL;
      region_o <= 6'h00;
    end else begin
      irq_take_o <= hw_ack; // (R01)
      ien_o <= ien;
      usel_o <= usel;
      ppl_o <= ppl;
      region_o <= region;
    end
  end
endmodule // cif_core_flags
`default_nettype wire

/* cif_defines.vh */
// Constants for the core interrupt flags and address decode block
`ifndef CIF_DEFINES_VH
`define CIF_DEFINES_VH
`define CIF_OFF_FLAGS 12'h000
`define CIF_OFF_REQ 12'h004
`define CIF_OFF_ACK 12'h008
`define CIF_OFF_SWI 12'h00C
`define CIF_OFF_DEC_ADDR 12'h010
`define CIF_OFF_DEC_RES 12'h014
`define CIF_OFF_BANK 12'h018
`define CIF_OFF_CORE 12'h020
`define CIF_BIT_IEN 0
`define CIF_BIT_USEL 1
`define CIF_BIT_RSV 2
`define CIF_POS_PPL 4
`define CIF_W_PPL 3
`define CIF_RST_IEN 1'h0
`define CIF_RST_USEL 1'h0
`define CIF_RST_PPL 3'h0
`define CIF_SWI_MAX 6'h1F
`define CIF_SPACE_TOP 20'hFFFFF
`define CIF_SPEC_LO 20'h00000
`define CIF_SPEC_HI 20'h002FF
`define CIF_RAM_LO 20'h00400
`define CIF_ROM_HI 20'h0FFFF
`define CIF_VEC_LO 20'h0FFDC
`define CIF_VEC_HI 20'h0FFFF
`define CIF_DFL_LO 20'h02400
`define CIF_DFL_HI 20'h02BFF
`define CIF_RAM_SIZE 20'h00400
`define CIF_ROM_SIZE 20'h04000
`define CIF_NUM_CORE 13
`define CIF_NUM_BANKED 7
`define CIF_HAS_DFL 1'h1
`define CIF_RSV_READ 32'h00000000
`endif

/* cif_irq_arb.v */
// Interrupt acceptance: enable flag and priority compare together
`timescale 1ns/10ps
`default_nettype none
module cif_irq_arb (
  input wire ien_i,
  input wire [2:0] ppl_i,
  input wire req_i,
  input wire [2:0] req_lvl_i,
  output wire accept_o
);
  // Both terms in one gate so neither can be stale against the other
  assign accept_o = req_i & ien_i & (req_lvl_i > ppl_i); // (R01) (R06) (R17)
endmodule // cif_irq_arb
`default_nettype wire

/* cif_addr_dec.v */
// Fixed address map decode of the 1 Mbyte space
`timescale 1ns/10ps
`default_nettype none
`include "cif_defines.vh"
module cif_addr_dec (
  input wire [19:0] addr_i,
  input wire dfl_en_i,
  output wire [5:0] region_o
);
  wire [19:0] rom_lo;
  wire [19:0] ram_hi;
  wire in_special;
  wire in_ram;
  wire in_rom;
  wire in_vec;
  wire in_dfl;
  wire in_none;
  assign rom_lo = `CIF_ROM_HI - `CIF_ROM_SIZE + 20'h00001; // (R09)
  assign ram_hi = `CIF_RAM_LO + `CIF_RAM_SIZE - 20'h00001; // (R11)
  assign in_special = addr_i <= `CIF_SPEC_HI; // (R13)
  assign in_ram = (addr_i >= `CIF_RAM_LO) && (addr_i <= ram_hi); // (R11) (R12)
  assign in_vec = (addr_i >= `CIF_VEC_LO) && (addr_i <= `CIF_VEC_HI); // (R10)
  assign in_rom = (addr_i >= rom_lo) && (addr_i <= `CIF_ROM_HI) && !in_vec;
  assign in_dfl = dfl_en_i && (addr_i >= `CIF_DFL_LO) &&
                  (addr_i <= `CIF_DFL_HI); // (R15)
  // Whole 20-bit space is covered; anything else falls to unmapped
  assign in_none = !(in_special | in_ram | in_rom | in_vec | in_dfl); // (R08)
  assign region_o = {in_none, in_dfl, in_vec, in_rom, in_ram, in_special};
endmodule // cif_addr_dec
`default_nettype wire

/* cif_core_flags_checker.sv */
// Port assertions for the core flag block
`timescale 1ns/10ps
`default_nettype none
module cif_chk (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic irq_take_o,
  input wire logic ien_o,
  input wire logic usel_o,
  input wire logic [2:0] ppl_o,
  input wire logic [5:0] region_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr;
  logic rq;
  logic [2:0] lvl;
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  assign rq = wr && paddr_i == 12'h004 && pwdata_i[0];
  // Level of the last request, to tie the new priority to it
  always @(posedge mclk_i) begin
    if (wr && paddr_i == 12'h004) begin
      lvl <= pwdata_i[3:1];
    end
  end
  take_flags_a: assert property (
    irq_take_o |=> !ien_o && !usel_o && ppl_o == lvl) else $error("bad take");
  take_accept_a: assert property (
    rq && ien_o && pwdata_i[3:1] > ppl_o |-> ##[1:3] irq_take_o)
    else $error("no take");
  mask_block_a: assert property (
    rq && !ien_o |=> !irq_take_o [*3]) else $error("masked take");
  low_level_a: assert property (
    rq && pwdata_i[3:1] <= ppl_o |=> !irq_take_o [*3]) else $error("low take");
  flag_read_a: assert property (
    pready_o && !pwrite_i && paddr_i == 12'h000 |->
    {prdata_o[6:4], prdata_o[2:0]} == {ppl_o, 1'b0, usel_o, ien_o})
    else $error("bad flag read");
  err_zero_a: assert property (
    pready_o && pslverr_o |-> prdata_o == 32'h0) else $error("err data");
  swi_clear_a: assert property (
    wr && paddr_i == 12'h00C && pwdata_i[5:0] <= 6'h1F |->
    ##2 !usel_o && !ien_o)
    else $error("swi kept flags");
  vec_region_a: assert property (
    wr && paddr_i == 12'h010 && pwdata_i[19:0] >= 20'h0FFDC &&
    pwdata_i[19:0] <= 20'h0FFFF |-> ##[1:2] region_o == 6'h08)
    else $error("bad vector region");
endmodule // cif_chk
bind cif_core_flags cif_chk cif_chk_i (.mclk_i, .rst_b_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .irq_take_o, .ien_o, .usel_o, .ppl_o, .region_o);
`default_nettype wire

/* cif_host.sv */
// Bus master model standing for the processor core
`timescale 1ns/10ps
`default_nettype none
module cif_host (
  input wire logic mclk_i,
  input wire logic pready_i,
  output logic psel_o = 1'b0,
  output logic penable_o = 1'b0,
  output logic pwrite_o = 1'b0,
  output logic [11:0] paddr_o = 12'h000,
  output logic [31:0] pwdata_o = 32'h0,
  output logic [3:0] pstrb_o = 4'hF
);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic to);
    integer n;
    begin
      n = 0;
      @(posedge mclk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= (a == 12'h000) ? (d & 32'hFFFFFFFB) : d;
      @(posedge mclk_i);
      penable_o <= 1'b1;
      // Slave outputs move by non-blocking update, so pready read at the
      // edge is the value that stood through the access cycle
      @(posedge mclk_i);
      while (pready_i !== 1'b1 && n < 50) begin
        @(posedge mclk_i);
        n = n + 1;
      end
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      to = (n == 50);
    end
  endtask
endmodule // cif_host
`default_nettype wire

/* cif_core_flags_tb.sv */
// Self-checking bench for the core flag block
`timescale 1ns/10ps
`default_nettype none
module cif_core_flags_tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic irq_take_o, ien_o, usel_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, u, v;
  logic [3:0] pstrb_i;
  logic [2:0] ppl_o;
  logic [5:0] region_o;
  logic [32:0] exp_q[$];
  logic [25:0] dec_t [0:11] = '{{20'h00000, 6'h01}, {20'h002FF, 6'h01},
    {20'h00300, 6'h20}, {20'h00400, 6'h02}, {20'h007FF, 6'h02},
    {20'h00800, 6'h20}, {20'h02400, 6'h10}, {20'h02BFF, 6'h10},
    {20'h0C000, 6'h04}, {20'h0FFDB, 6'h04}, {20'h0FFDC, 6'h08},
    {20'hFFFFF, 6'h20}};
  integer fail_count = 0;
  integer check_count = 0;
  integer seed = 32'hcc54;
  integer k;
  initial forever #2.5 mclk_i = ~mclk_i;
  cif_host cif_host_i (.mclk_i, .pready_i(pready_o), .psel_o(psel_i),
    .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
    .pwdata_o(pwdata_i), .pstrb_o(pstrb_i));
  cif_core_flags cif_core_flags_i (.mclk_i, .rst_b_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .irq_take_o, .ien_o, .usel_o, .ppl_o, .region_o);
  task check(input logic [32:0] s, input logic [32:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic to;
    cif_host_i.xfer(w, a, d, to);
    if (to) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && pwrite_i === 1'b0) begin
      check({pslverr_o, prdata_o}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(12'h000, 33'h0);
    bus(1'b1, 12'h000, 32'h35);
    rd(12'h000, 33'h31);
    bus(1'b1, 12'h004, 32'h7);
    rd(12'h000, 33'h31);
    bus(1'b1, 12'h004, 32'hB);
    rd(12'h000, 33'h50);
    bus(1'b1, 12'h004, 32'hF);
    rd(12'h000, 33'h50);
    bus(1'b1, 12'h004, 32'h0);
    $display("irq test done");
    u = $random(seed) & 32'hFFFF;
    v = $random(seed) & 32'hFFFF;
    bus(1'b1, 12'h000, 32'h2);
    bus(1'b1, 12'h008, u);
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, 12'h008, v);
    rd(12'h008, {1'b0, v});
    bus(1'b1, 12'h000, 32'h2);
    rd(12'h008, {1'b0, u});
    bus(1'b1, 12'h000, 32'h3);
    bus(1'b1, 12'h00C, 32'h20);
    rd(12'h000, 33'h3);
    bus(1'b1, 12'h00C, 32'h1F);
    rd(12'h000, 33'h0);
    bus(1'b1, 12'h000, 32'h3);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(12'h000, 33'h0);
    $display("stack test done");
    bus(1'b1, 12'h020, u);
    bus(1'b1, 12'h018, 32'h1);
    bus(1'b1, 12'h020, v);
    rd(12'h020, {1'b0, v});
    bus(1'b1, 12'h018, 32'h0);
    rd(12'h020, {1'b0, u});
    bus(1'b1, 12'h050, v);
    bus(1'b1, 12'h018, 32'h1);
    bus(1'b1, 12'h038, u);
    rd(12'h050, {1'b0, v});
    rd(12'h038, {1'b0, u});
    rd(12'h0FC, 33'h100000000);
    $display("bank test done");
    for (k = 0; k < 12; k = k + 1) begin
      bus(1'b1, 12'h010, {12'h0, dec_t[k][25:6]});
      rd(12'h014, {27'h0, dec_t[k][5:0]});
    end
    $display("decode test done");
    stop_test;
  end
endmodule // cif_core_flags_tb
`default_nettype wire
